// File: verilog/xor_instruction_exec.sv
// Execution of the two exclusive-OR instructions on a four-phase instruction cycle.
// Assumes one instruction word is presented per cycle and held through its four phases.
//
// Functional notes
// (RQ1) Literal form XORs literal into accumulator
// (RQ2) Register form XORs accumulator with file register
// (RQ3) Destination 0 writes accumulator only
// (RQ4) Destination 1 writes file register only
// (RQ5) Operands: accumulator and seven-bit addressed register
// (RQ6) One word, four phases, zero on result
`timescale 1ns/10ps
module xor_instruction_exec (
    // Clock and reset
    input  wire logic                                   i_clock,
    input  wire logic                                   i_reset,
    // Instruction
    input  wire logic [xor_exec_pkg::INSTR_WIDTH-1:0]   i_instr,
    // Debug access to file registers
    input  wire logic [xor_exec_pkg::ADDR_WIDTH-1:0]    i_peek_addr,
    // Results
    output logic      [xor_exec_pkg::DATA_WIDTH-1:0]    o_acc,
    output logic                                        o_zero,
    output logic                                        o_cycle_done,
    output logic                                        o_file_we,
    output logic      [xor_exec_pkg::ADDR_WIDTH-1:0]    o_file_addr,
    output logic      [xor_exec_pkg::DATA_WIDTH-1:0]    o_file_data,
    output logic      [xor_exec_pkg::DATA_WIDTH-1:0]    o_peek_data
);

    xor_exec_pkg::phase_t      phase;
    xor_exec_pkg::phase_t      next_phase;
    xor_exec_pkg::decoded_t    dec;
    xor_exec_pkg::decoded_t    next_dec;
    xor_exec_pkg::core_state_t core;
    xor_exec_pkg::core_state_t next_core;

    logic [xor_exec_pkg::DATA_WIDTH-1:0] operand;
    logic [xor_exec_pkg::DATA_WIDTH-1:0] next_operand;
    logic [xor_exec_pkg::DATA_WIDTH-1:0] result;
    logic [xor_exec_pkg::DATA_WIDTH-1:0] next_result;
    logic [xor_exec_pkg::DATA_WIDTH-1:0] mem_rdata;
    logic                                next_cycle_done;
    logic                                next_file_we;
    logic                                mem_we;
    logic [xor_exec_pkg::ADDR_WIDTH-1:0] mem_raddr;

    // The memory read port serves the decoded address in the decode phase and
    // the peek address otherwise; peek data is therefore stale by one cycle.
    always_comb begin
        mem_raddr = (phase == xor_exec_pkg::PH_DECODE) ? next_dec.addr : i_peek_addr;
        mem_we    = o_file_we;
    end

    file_reg_mem u_file_reg_mem (
        .i_clock      (i_clock),
        .i_reset      (i_reset),
        .i_read_addr  (mem_raddr),
        .o_read_data  (mem_rdata),
        .i_write_en   (mem_we),
        .i_write_addr (o_file_addr),
        .i_write_data (o_file_data)
    );

    // Phase sequencer and decode
    always_comb begin
        next_phase = phase;
        next_dec   = dec;
        unique case (phase)
            xor_exec_pkg::PH_DECODE: begin
                next_phase       = xor_exec_pkg::PH_READ; // RQ6
                next_dec.is_lit  = i_instr[xor_exec_pkg::LIT_OPC_MSB:xor_exec_pkg::LIT_OPC_LSB]
                                   == xor_exec_pkg::LIT_OPCODE; // RQ1
                next_dec.is_reg  = i_instr[xor_exec_pkg::REG_OPC_MSB:xor_exec_pkg::REG_OPC_LSB]
                                   == xor_exec_pkg::REG_OPCODE; // RQ2
                next_dec.dest_file = i_instr[xor_exec_pkg::DEST_BIT];
                next_dec.addr    = i_instr[xor_exec_pkg::ADDR_MSB:xor_exec_pkg::ADDR_LSB]; // RQ5
                next_dec.literal = i_instr[xor_exec_pkg::LIT_MSB:xor_exec_pkg::LIT_LSB];
            end
            xor_exec_pkg::PH_READ:    next_phase = xor_exec_pkg::PH_COMPUTE;
            xor_exec_pkg::PH_COMPUTE: next_phase = xor_exec_pkg::PH_WRITE;
            xor_exec_pkg::PH_WRITE:   next_phase = xor_exec_pkg::PH_DECODE;
            default:                  next_phase = xor_exec_pkg::PH_DECODE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            phase <= xor_exec_pkg::PH_DECODE;
            dec   <= '0;
        end else begin
            phase <= next_phase;
            dec   <= next_dec;
        end
    end

    // Datapath: operand fetch, XOR, write-back
    always_comb begin
        next_operand    = operand;
        next_result     = result;
        next_core       = core;
        next_file_we    = 1'b0;
        next_cycle_done = 1'b0;
        if (phase == xor_exec_pkg::PH_READ) begin
            next_operand = dec.is_lit ? dec.literal : mem_rdata; // RQ5
        end
        if (phase == xor_exec_pkg::PH_COMPUTE) begin
            next_result = core.acc ^ operand; // RQ1 RQ2
        end
        if (phase == xor_exec_pkg::PH_WRITE) begin
            next_cycle_done = 1'b1; // RQ6
            if (dec.is_lit || dec.is_reg) begin
                next_core.zero = (result == '0); // RQ6
            end
            if (dec.is_lit || (dec.is_reg && dec.dest_file == xor_exec_pkg::DEST_ACC)) begin
                next_core.acc = result; // RQ1 RQ3
            end
            if (dec.is_reg && dec.dest_file != xor_exec_pkg::DEST_ACC) begin
                next_file_we = 1'b1; // RQ4
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            operand      <= '0;
            result       <= '0;
            core.acc     <= xor_exec_pkg::ACC_RESET;
            core.zero    <= 1'b0;
            o_file_we    <= 1'b0;
            o_cycle_done <= 1'b0;
            o_file_addr  <= '0;
            o_file_data  <= '0;
        end else begin
            operand      <= next_operand;
            result       <= next_result;
            core         <= next_core;
            o_file_we    <= next_file_we;
            o_cycle_done <= next_cycle_done;
            o_file_addr  <= dec.addr;
            o_file_data  <= result;
        end
    end

    always_comb begin
        o_acc       = core.acc;
        o_zero      = core.zero;
        o_peek_data = mem_rdata;
    end

    AST_LIT_ACC: assert property (@(posedge i_clock) disable iff (i_reset)
        (phase == xor_exec_pkg::PH_WRITE && dec.is_lit) |=> (o_acc == $past(result)))
        else $error("literal result not in accumulator"); // RQ1
    AST_REG_XOR: assert property (@(posedge i_clock) disable iff (i_reset)
        (phase == xor_exec_pkg::PH_COMPUTE && dec.is_reg) |=> (result == (o_acc ^ operand)))
        else $error("register form result wrong"); // RQ2
    AST_DEST_ACC: assert property (@(posedge i_clock) disable iff (i_reset)
        (phase == xor_exec_pkg::PH_WRITE && dec.is_reg && !dec.dest_file)
        |=> (!o_file_we && o_acc == $past(result)))
        else $error("destination 0 misrouted"); // RQ3
    AST_DEST_FILE: assert property (@(posedge i_clock) disable iff (i_reset)
        (phase == xor_exec_pkg::PH_WRITE && dec.is_reg && dec.dest_file)
        |=> (o_file_we && $stable(o_acc) && o_file_data == $past(result)))
        else $error("destination 1 misrouted"); // RQ4
    AST_OPERAND: assert property (@(posedge i_clock) disable iff (i_reset)
        (phase == xor_exec_pkg::PH_READ && dec.is_reg) |=> (operand == $past(mem_rdata)))
        else $error("operand not from file register"); // RQ5
    AST_CYCLE: assert property (@(posedge i_clock) disable iff (i_reset)
        o_cycle_done |=> !o_cycle_done ##1 !o_cycle_done ##1 !o_cycle_done ##1 o_cycle_done)
        else $error("instruction cycle not four phases"); // RQ6
    AST_ZERO: assert property (@(posedge i_clock) disable iff (i_reset)
        (phase == xor_exec_pkg::PH_WRITE && (dec.is_lit || dec.is_reg))
        |=> (o_zero == ($past(result) == 8'h00)))
        else $error("zero flag wrong"); // RQ6
    AST_NOP: assert property (@(posedge i_clock) disable iff (i_reset)
        (phase == xor_exec_pkg::PH_WRITE && !dec.is_lit && !dec.is_reg)
        |=> ($stable(o_acc) && $stable(o_zero) && !o_file_we))
        else $error("other opcode changed state"); // RQ1

endmodule // xor_instruction_exec

// File: verilog/xor_exec_pkg.sv
// Package for the exclusive-OR execution block: opcode fields, phases, carriers.
// Assumes a 14-bit instruction word and an 8-bit data path.
package xor_exec_pkg;

    localparam int INSTR_WIDTH      = 14;
    localparam int DATA_WIDTH       = 8;
    localparam int ADDR_WIDTH       = 7;
    localparam int FILE_DEPTH       = 128;

    // Literal form: bits 13:8 equal 11 1010
    localparam int                 LIT_OPC_MSB     = 13;
    localparam int                 LIT_OPC_LSB     = 8;
    localparam logic [5:0]         LIT_OPCODE      = 6'h3A;
    // Register form: bits 13:8 equal 00 0110
    localparam int                 REG_OPC_MSB     = 13;
    localparam int                 REG_OPC_LSB     = 8;
    localparam logic [5:0]         REG_OPCODE      = 6'h06;
    localparam int                 DEST_BIT        = 7;
    localparam int                 ADDR_MSB        = 6;
    localparam int                 ADDR_LSB        = 0;
    localparam int                 LIT_MSB         = 7;
    localparam int                 LIT_LSB         = 0;

    localparam logic [7:0]         ACC_RESET       = 8'h00;
    localparam logic [7:0]         FILE_RESET      = 8'h00;
    localparam logic               DEST_ACC        = 1'b0;

    // Four phases per instruction cycle
    typedef enum logic [3:0] {
        PH_DECODE  = 4'h1,
        PH_READ    = 4'h2,
        PH_COMPUTE = 4'h4,
        PH_WRITE   = 4'h8
    } phase_t;

    typedef struct packed {
        logic                  is_lit;
        logic                  is_reg;
        logic                  dest_file;
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] literal;
    } decoded_t;

    typedef struct packed {
        logic [DATA_WIDTH-1:0] acc;
        logic                  zero;
    } core_state_t;

endpackage

// File: verilog/file_reg_mem.sv
// File register storage, 128 bytes, one write port and one registered read port.
// Assumes writes and reads are steered by the execution sequencer.
`timescale 1ns/10ps
module file_reg_mem (
    // Clock and reset
    input  wire logic                                  i_clock,
    input  wire logic                                  i_reset,
    // Read port
    input  wire logic [xor_exec_pkg::ADDR_WIDTH-1:0]   i_read_addr,
    output logic      [xor_exec_pkg::DATA_WIDTH-1:0]   o_read_data,
    // Write port
    input  wire logic                                  i_write_en,
    input  wire logic [xor_exec_pkg::ADDR_WIDTH-1:0]   i_write_addr,
    input  wire logic [xor_exec_pkg::DATA_WIDTH-1:0]   i_write_data
);

    logic [xor_exec_pkg::DATA_WIDTH-1:0] store [xor_exec_pkg::FILE_DEPTH];
    logic [xor_exec_pkg::DATA_WIDTH-1:0] next_read_data;

    // A write and a read of one register on the same edge return the new value,
    // so an instruction sees the result its predecessor wrote back
    always_comb begin
        if (i_write_en && (i_write_addr == i_read_addr)) begin
            next_read_data = i_write_data;
        end else begin
            next_read_data = store[i_read_addr];
        end
    end

    // Cleared by reset so that register contents are never unknown
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            for (int idx = 0; idx < xor_exec_pkg::FILE_DEPTH; idx++) begin
                store[idx] <= xor_exec_pkg::FILE_RESET;
            end
        end else if (i_write_en) begin
            store[i_write_addr] <= i_write_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_read_data <= xor_exec_pkg::FILE_RESET;
        end else begin
            o_read_data <= next_read_data;
        end
    end

endmodule // file_reg_mem

// File: sim/testbench.sv
// Self-checking bench for the exclusive-OR execution block, one task per scenario.
// Assumes one instruction per four clocks; file registers clear on reset, and the model with them.
`timescale 1ns/10ps
module testbench;
    logic        i_clock;
    logic        i_reset;
    logic [13:0] i_instr;
    logic [6:0]  i_peek_addr;
    logic [7:0]  o_acc;
    logic        o_zero;
    logic        o_cycle_done;
    logic        o_file_we;
    logic [6:0]  o_file_addr;
    logic [7:0]  o_file_data;
    logic [7:0]  o_peek_data;
    logic [7:0]  acc_m;
    logic        zero_m;
    logic [7:0]  mem_m [128];
    int          error_cnt;
    int          tests_run;

    xor_instruction_exec dut (
        .i_clock      (i_clock),
        .i_reset      (i_reset),
        .i_instr      (i_instr),
        .i_peek_addr  (i_peek_addr),
        .o_acc        (o_acc),
        .o_zero       (o_zero),
        .o_cycle_done (o_cycle_done),
        .o_file_we    (o_file_we),
        .o_file_addr  (o_file_addr),
        .o_file_data  (o_file_data),
        .o_peek_data  (o_peek_data)
    );

    always #25 i_clock = ~i_clock;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic do_reset();
        i_reset = 1'b1;
        repeat (2) @(posedge i_clock);
        #1 i_reset = 1'b0;
        acc_m  = xor_exec_pkg::ACC_RESET;
        zero_m = 1'b0;
        for (int idx = 0; idx < 128; idx++) begin
            mem_m[idx] = xor_exec_pkg::FILE_RESET;
        end
        check(o_acc, 8'h00);
        check({7'h00, o_zero}, 8'h00);
        check({6'h00, o_file_we, o_cycle_done}, 8'h00);
    endtask

    // Runs one instruction cycle, updates the model and compares all results after the write phase
    task automatic exec(input logic [13:0] instr);
        logic [7:0] res;
        logic       we;
        we      = 1'b0;
        res     = 8'h00;
        i_instr = instr;
        if (instr[13:8] === xor_exec_pkg::LIT_OPCODE) begin
            res    = acc_m ^ instr[7:0];
            acc_m  = res;
            zero_m = (res == 8'h00);
        end else if (instr[13:8] === xor_exec_pkg::REG_OPCODE) begin
            res    = acc_m ^ mem_m[instr[6:0]];
            zero_m = (res == 8'h00);
            if (instr[7]) begin
                mem_m[instr[6:0]] = res;
                we = 1'b1;
            end else begin
                acc_m = res;
            end
        end
        repeat (4) @(posedge i_clock);
        #1;
        check(o_acc, acc_m);
        check({7'h00, o_zero}, {7'h00, zero_m});
        check({7'h00, o_file_we}, {7'h00, we});
        check({7'h00, o_cycle_done}, 8'h01);
        if (we) begin
            check({1'b0, o_file_addr}, {1'b0, instr[6:0]});
            check(o_file_data, res);
        end
    endtask

    // Non-XOR word whose address field matches the peek address keeps the read port on it
    task automatic peek(input logic [6:0] a);
        i_instr     = {7'h00, a};
        i_peek_addr = a;
        repeat (8) @(posedge i_clock);
        #1;
        check(o_peek_data, mem_m[a]);
    endtask

    task automatic test_literal();
        do_reset();
        exec({6'h3A, 8'hB5});
        exec({6'h3A, 8'hAF});
        check(o_acc, 8'h1A);
        exec({6'h3A, 8'h1A});
        check({7'h00, o_zero}, 8'h01);
        exec({6'h3A, 8'hFF});
        exec({6'h3A, 8'h00});
        $display("test literal done");
    endtask

    task automatic test_refused();
        do_reset();
        exec({6'h3A, 8'h3C});
        exec({6'h0E, 8'h85});
        exec(14'h3FFF);
        check(o_acc, 8'h3C);
        $display("test other opcodes done");
    endtask

    task automatic test_reg_file();
        do_reset();
        peek(7'h05);
        peek(7'h06);
        exec({6'h3A, 8'hAF});
        exec({6'h06, 1'b1, 7'h05});
        exec({6'h3A, 8'hAF});
        exec({6'h3A, 8'hB5});
        exec({6'h06, 1'b1, 7'h05});
        check(o_acc, 8'hB5);
        check(o_file_data, 8'h1A);
        exec({6'h06, 1'b1, 7'h06});
        peek(7'h05);
        check(o_peek_data, 8'h1A);
        peek(7'h06);
        $display("test register to file done");
    endtask

    task automatic test_reg_acc();
        do_reset();
        peek(7'h7F);
        peek(7'h00);
        exec({6'h3A, 8'hA5});
        exec({6'h06, 1'b1, 7'h7F});
        exec({6'h06, 1'b0, 7'h7F});
        check({7'h00, o_zero}, 8'h01);
        exec({6'h3A, 8'h3C});
        exec({6'h06, 1'b0, 7'h00});
        exec({6'h06, 1'b1, 7'h00});
        exec({6'h06, 1'b0, 7'h7F});
        check(o_acc, 8'h99);
        peek(7'h7F);
        peek(7'h00);
        $display("test register to accumulator done");
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        i_clock     = 1'b0;
        i_reset     = 1'b1;
        i_instr     = 14'h0000;
        i_peek_addr = 7'h00;
        error_cnt   = 0;
        tests_run   = 0;
        repeat (16) @(posedge i_clock);
        #1;
        test_literal();
        test_refused();
        test_reg_file();
        test_reg_acc();
        results();
    end
endmodule // testbench
